// [eeprom_autoload_mapper.sv]
// The Avalon-MM register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
// autoload of controller settings from the serial configuration eeprom
module eeprom_autoload_mapper
	import eeprom_map_pkg::*;
#(
	parameter logic [15:0] ID_WORD = 16'h5A3C, // arbitrary value, set per product
	parameter int HALF_CYC = SK_HALF_CYC
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// avalon-mm slave
	input wire logic [7:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	output logic [31:0] readdata,
	output logic waitrequest,
	// serial eeprom
	output ee_pins_s ee_pins,
	input wire logic ee_do,
	// link and power pins
	input wire logic link_down,
	input wire logic signal_detect,
	output logic tx_power_down,
	output logic rx_monitor_on,
	// wake logic, same clock domain
	input wire logic wake_event,
	input wire logic pci_reset,
	output logic wake_pin,
	// loaded values for the rest of the controller
	output load_cfg_s cfg_q,
	output logic cfg_valid
);
	initial begin
		if (HALF_CYC < 1) $error("HALF_CYC must be at least one");
	end

	typedef enum logic [4:0] {
		AL_IDLE = 5'b00001,
		AL_ISSUE = 5'b00010,
		AL_WAIT = 5'b00100,
		AL_CHECK = 5'b01000,
		AL_APPLY = 5'b10000
	} al_state_e;

	// little-endian gather of bytes from the image
	function automatic logic [31:0] img_dword(input logic [7:0] img [0:IMG_BYTES-1],
		input int base);
		img_dword = {img[base+3], img[base+2], img[base+1], img[base]};
	endfunction : img_dword

	al_state_e state_q;
	logic [7:0] img_q [0:IMG_BYTES-1];
	logic [EE_ADDR_W-1:0] word_q;
	logic rd_start;
	logic rd_done;
	logic [EE_WORD_W-1:0] rd_data;
	logic load_req_q;
	logic id_fail_q;
	logic variant_t_q;
	logic wake_flag_q;
	logic ack_q;
	logic [2:0] do_sync_q;
	logic [1:0] link_down_sync_q;
	logic [1:0] sd_sync_q;
	logic sw_reload;
	logic sw_wake_clear;
	logic bus_req;

	// pins from outside pass two flops before use
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			do_sync_q <= '0;
			link_down_sync_q <= '0;
			sd_sync_q <= '0;
		end else begin
			do_sync_q <= {do_sync_q[1:0], ee_do};
			link_down_sync_q <= {link_down_sync_q[0], link_down};
			sd_sync_q <= {sd_sync_q[0], signal_detect};
		end
	end

	eeprom_word_reader #(
		.HALF_CYC(HALF_CYC)
	) u_reader (
		.sys_clk(sys_clk),
		.rst(rst),
		.start(rd_start),
		.addr(word_q),
		.busy(),
		.done(rd_done),
		.data_q(rd_data),
		.do_sync(do_sync_q[1]),
		.pins(ee_pins)
	);

	assign rd_start = (state_q == AL_ISSUE);

	// avalon handshake: every access answers one cycle after it is presented
	assign bus_req = (read || write) && !ack_q;
	assign waitrequest = (read || write) && !ack_q;
	assign sw_reload = write && !ack_q && (address == RA_CTRL) && byteenable[0]
		&& writedata[CTRL_RELOAD];
	assign sw_wake_clear = write && !ack_q && (address == RA_WAKE) && byteenable[0]
		&& writedata[WAKE_CLEAR];

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= bus_req;
		end
	end

	// a load is pending from reset onward, and again on each reload command
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			load_req_q <= 1'b1;
		end else if (sw_reload) begin
			load_req_q <= 1'b1;
		end else if (state_q == AL_IDLE) begin
			load_req_q <= 1'b0;
		end
	end

	// variant select steers which tuning set lands in the shared registers
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			variant_t_q <= 1'b0;
		end else if (write && !ack_q && address == RA_CTRL && byteenable[0]) begin
			variant_t_q <= writedata[CTRL_VARIANT_T];
		end
	end

	// sequencer: read words 0 up to the last mapped word, checking the id first
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state_q <= AL_IDLE;
			word_q <= '0;
			id_fail_q <= 1'b0;
		end else begin
			case (state_q)
				AL_IDLE: begin
					if (load_req_q) begin
						word_q <= '0;
						id_fail_q <= 1'b0;
						state_q <= AL_ISSUE;
					end
				end
				AL_ISSUE: begin
					state_q <= AL_WAIT;
				end
				AL_WAIT: begin
					if (rd_done) begin
						state_q <= AL_CHECK;
					end
				end
				AL_CHECK: begin
					if (word_q == '0 && {img_q[EB_ID+1], img_q[EB_ID]} != ID_WORD) begin
						id_fail_q <= 1'b1;
						state_q <= AL_IDLE;
					end else if (word_q == EE_LAST_WORD) begin
						// stops below the product data area, which stays free for product data access
						state_q <= AL_APPLY;
					end else begin
						word_q <= word_q + EE_ADDR_W'(1);
						state_q <= AL_ISSUE;
					end
				end
				AL_APPLY: begin
					state_q <= AL_IDLE;
				end
				default: begin
					state_q <= AL_IDLE;
				end
			endcase
		end
	end

	// staging image; nothing reaches the live registers until the load completes
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < IMG_BYTES; i++) begin
				img_q[i] <= '0;
			end
		end else if (state_q == AL_WAIT && rd_done) begin
			img_q[2*int'(word_q)] <= rd_data[7:0];
			img_q[2*int'(word_q)+1] <= rd_data[15:8];
		end
	end

	// live registers: the values from before the load, reset defaults or the last good load, stay when the load is abandoned
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cfg_q <= '0;
		end else if (state_q == AL_APPLY) begin
			cfg_q.station_address_regs <= {img_q[EB_STATION+5], img_q[EB_STATION+4],
				img_dword(img_q, EB_STATION)};
			cfg_q.wake_feature_settings <= img_q[EB_CFG3];
			cfg_q.boot_rom_size_settings <= img_q[EB_CFG0];
			cfg_q.led_and_mapping_settings <= img_q[EB_CFG1];
			cfg_q.power_capability_word <= {img_q[EB_PMC+1], img_q[EB_PMC]};
			cfg_q.power_control_status <= img_q[EB_PMCS];
			cfg_q.fifo_and_pattern_settings <= img_q[EB_CFG4];
			cfg_q.option_bits <= img_q[EB_OPT5];
			if (variant_t_q) begin
				cfg_q.phy_tuning_a <= img_dword(img_q, EB_PHYA_T);
				cfg_q.phy_tuning_b <= img_q[EB_PHYB_T];
				cfg_q.line_driver_tuning <= img_dword(img_q, EB_LDRV_T);
			end else begin
				cfg_q.phy_tuning_a <= img_dword(img_q, EB_PHYA_U);
				cfg_q.phy_tuning_b <= img_q[EB_PHYB_U];
				cfg_q.line_driver_tuning <= img_dword(img_q, EB_LDRV_U);
			end
		end
	end

	// valid drops while a load runs and rises only after a full, matching load
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cfg_valid <= 1'b0;
		end else if (state_q == AL_APPLY) begin
			cfg_valid <= 1'b1;
		end else if (state_q == AL_ISSUE && word_q == '0) begin
			cfg_valid <= 1'b0;
		end
	end

	// wake flag: an event in the clearing cycle wins over the clear
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			wake_flag_q <= 1'b0;
		end else if (wake_event) begin
			wake_flag_q <= 1'b1;
		end else if (sw_wake_clear) begin
			wake_flag_q <= 1'b0;
		end else if (pci_reset && cfg_q.option_bits[OPT_STICKY_SEL]
			&& !cfg_q.power_capability_word[PMC_COLD_WAKE]) begin
			wake_flag_q <= 1'b0;
		end
	end

	// link-loss power saving: receive stays on so reconnection is still seen
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			tx_power_down <= 1'b0;
			rx_monitor_on <= 1'b1;
			wake_pin <= 1'b0;
		end else begin
			tx_power_down <= link_down_sync_q[1] && !sd_sync_q[1]
				&& !cfg_q.option_bits[OPT_LDPS_OFF];
			rx_monitor_on <= 1'b1;
			wake_pin <= wake_flag_q && cfg_q.option_bits[OPT_WAKE_PIN_EN];
		end
	end

	// register read mux, data captured with the answering edge
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			readdata <= '0;
		end else if (read && !ack_q) begin
			case (address)
				RA_CTRL: readdata <= {30'h0000_0000, variant_t_q, 1'b0};
				RA_STATUS: readdata <= {28'h000_0000, wake_flag_q, id_fail_q, cfg_valid,
					(state_q != AL_IDLE) || load_req_q};
				RA_STATION_LO: readdata <= cfg_q.station_address_regs[31:0];
				RA_STATION_HI: readdata <= {16'h0000, cfg_q.station_address_regs[47:32]};
				RA_CONFIG: readdata <= {cfg_q.fifo_and_pattern_settings,
					cfg_q.wake_feature_settings, cfg_q.led_and_mapping_settings,
					cfg_q.boot_rom_size_settings};
				RA_POWER: readdata <= {cfg_q.option_bits, cfg_q.power_control_status,
					cfg_q.power_capability_word};
				RA_PHY_A: readdata <= cfg_q.phy_tuning_a;
				RA_LINE_DRV: readdata <= cfg_q.line_driver_tuning;
				RA_PHY_B: readdata <= {24'h00_0000, cfg_q.phy_tuning_b};
				RA_WAKE: readdata <= {31'h0000_0000, wake_flag_q};
				default: readdata <= '0;
			endcase
		end
	end
endmodule : eeprom_autoload_mapper

// [eeprom_map_pkg.sv]
package eeprom_map_pkg;
	// eeprom geometry: 16-bit words, byte 2w is the low half of word w
	localparam int EE_ADDR_W = 6;
	localparam int EE_WORD_W = 16;
	localparam int EE_CMD_BITS = 9;
	localparam int EE_RX_BITS = 17;
	localparam logic [2:0] EE_READ_OP = 3'h6;
	localparam logic [EE_ADDR_W-1:0] EE_LAST_WORD = 6'h16;
	localparam int IMG_BYTES = 46;
	// serial clock half period, kept well inside slow parts' limits
	localparam int SK_HALF_NS = 500;
	localparam int CLK_NS = 25;
	localparam int SK_HALF_CYC = (SK_HALF_NS + CLK_NS - 1) / CLK_NS;
	// eeprom byte locations
	localparam int EB_ID = 'h00;
	localparam int EB_CFG3 = 'h0D;
	localparam int EB_STATION = 'h0E;
	localparam int EB_CFG0 = 'h14;
	localparam int EB_CFG1 = 'h15;
	localparam int EB_PMC = 'h16;
	localparam int EB_PMCS = 'h18;
	localparam int EB_CFG4 = 'h19;
	localparam int EB_PHYA_U = 'h1A;
	localparam int EB_PHYB_U = 'h1E;
	localparam int EB_OPT5 = 'h1F;
	localparam int EB_LDRV_U = 'h20;
	localparam int EB_LDRV_T = 'h24;
	localparam int EB_PHYA_T = 'h28;
	localparam int EB_PHYB_T = 'h2C;
	localparam int EB_CHECKSUM = 'h32;
	localparam int EB_NETBOOT = 'h3F;
	localparam int EB_PRODUCT_DATA = 'h40;
	// option byte fields
	localparam int OPT_STICKY_SEL = 0;
	localparam int OPT_WAKE_PIN_EN = 1;
	localparam int OPT_LDPS_OFF = 2;
	// power capability word: cold-state wake support bit
	localparam int PMC_COLD_WAKE = 15;
	// avalon register byte addresses
	localparam logic [7:0] RA_CTRL = 8'h00;
	localparam logic [7:0] RA_STATUS = 8'h04;
	localparam logic [7:0] RA_STATION_LO = 8'h08;
	localparam logic [7:0] RA_STATION_HI = 8'h0C;
	localparam logic [7:0] RA_CONFIG = 8'h10;
	localparam logic [7:0] RA_POWER = 8'h14;
	localparam logic [7:0] RA_PHY_A = 8'h18;
	localparam logic [7:0] RA_LINE_DRV = 8'h1C;
	localparam logic [7:0] RA_PHY_B = 8'h20;
	localparam logic [7:0] RA_WAKE = 8'h24;
	// control and status fields
	localparam int CTRL_RELOAD = 0;
	localparam int CTRL_VARIANT_T = 1;
	localparam int ST_BUSY = 0;
	localparam int ST_VALID = 1;
	localparam int ST_ID_FAIL = 2;
	localparam int ST_WAKE_FLAG = 3;
	localparam int WAKE_CLEAR = 0;
	// serial eeprom outputs
	typedef struct packed {
		logic cs;
		logic sk;
		logic di;
	} ee_pins_s;
	// everything the autoload fills
	typedef struct packed {
		logic [47:0] station_address_regs;
		logic [7:0] wake_feature_settings;
		logic [7:0] boot_rom_size_settings;
		logic [7:0] led_and_mapping_settings;
		logic [7:0] fifo_and_pattern_settings;
		logic [15:0] power_capability_word;
		logic [7:0] power_control_status;
		logic [7:0] option_bits;
		logic [31:0] phy_tuning_a;
		logic [31:0] line_driver_tuning;
		logic [7:0] phy_tuning_b;
	} load_cfg_s;
endpackage : eeprom_map_pkg

// [eeprom_word_reader.sv]
`timescale 1ns/1ps
// reads one 16-bit word from a three-wire serial eeprom
module eeprom_word_reader
	import eeprom_map_pkg::*;
#(
	parameter int HALF_CYC = SK_HALF_CYC
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// request
	input wire logic start,
	input wire logic [EE_ADDR_W-1:0] addr,
	output logic busy,
	output logic done,
	output logic [EE_WORD_W-1:0] data_q,
	// pins; do_sync already passed two flops
	input wire logic do_sync,
	output ee_pins_s pins
);
	localparam int LAST_BIT = EE_CMD_BITS + EE_RX_BITS - 1;
	localparam int CNT_W = $clog2(HALF_CYC + 1);

	initial begin
		if (HALF_CYC < 1) $error("HALF_CYC must be at least one");
	end

	typedef enum logic [1:0] {
		RD_IDLE = 2'b01,
		RD_RUN = 2'b10
	} rd_state_e;

	rd_state_e state_q;
	logic [CNT_W-1:0] div_q;
	logic tick;
	logic [4:0] bit_q;
	logic [EE_CMD_BITS-1:0] cmd_q;
	logic done_q;

	assign busy = (state_q != RD_IDLE) || start;
	assign done = done_q;
	assign tick = (div_q == CNT_W'(HALF_CYC - 1));

	// serial clock enable divider, restarted with each word
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			div_q <= '0;
		end else if (state_q == RD_IDLE || tick) begin
			div_q <= '0;
		end else begin
			div_q <= div_q + CNT_W'(1);
		end
	end

	// command shift out on each falling serial clock, data shift in on each rising serial clock after the command bits
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state_q <= RD_IDLE;
			pins <= '0;
			bit_q <= '0;
			cmd_q <= '0;
			data_q <= '0;
			done_q <= 1'b0;
		end else begin
			done_q <= 1'b0;
			case (state_q)
				RD_IDLE: begin
					if (start) begin
						cmd_q <= {EE_READ_OP, addr} << 1;
						pins.di <= EE_READ_OP[2];
						pins.cs <= 1'b1;
						pins.sk <= 1'b0;
						bit_q <= '0;
						state_q <= RD_RUN;
					end
				end
				RD_RUN: begin
					if (tick && !pins.sk) begin
						pins.sk <= 1'b1;
						// first sample is the dummy zero; it falls out the top
						if (bit_q >= 5'(EE_CMD_BITS)) begin
							data_q <= {data_q[EE_WORD_W-2:0], do_sync};
						end
					end else if (tick) begin
						pins.sk <= 1'b0;
						if (bit_q == 5'(LAST_BIT)) begin
							pins.cs <= 1'b0;
							pins.di <= 1'b0;
							done_q <= 1'b1;
							state_q <= RD_IDLE;
						end else begin
							bit_q <= bit_q + 5'd1;
							pins.di <= cmd_q[EE_CMD_BITS-1];
							cmd_q <= cmd_q << 1;
						end
					end
				end
				default: begin
					state_q <= RD_IDLE;
				end
			endcase
		end
	end
endmodule : eeprom_word_reader

// [eeprom_autoload_assertions.sv]
`timescale 1ns/1ps
// protocol checks at the autoload block's ports
module eeprom_autoload_assertions
	import eeprom_map_pkg::*;
#(
	parameter int HALF_CYC = SK_HALF_CYC
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// bus handshake
	input wire logic read,
	input wire logic write,
	input wire logic waitrequest,
	// eeprom pins and loaded outputs
	input wire ee_pins_s ee_pins,
	input wire logic wake_pin,
	input wire logic tx_power_down,
	input wire logic rx_monitor_on,
	input wire load_cfg_s cfg_q,
	input wire logic cfg_valid
);
	logic [7:0] hi_q;
	logic [5:0] rises_q;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	// length of the current sk high phase, in clocks
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			hi_q <= 8'h00;
		end else begin
			hi_q <= ee_pins.sk ? hi_q + 8'h01 : 8'h00;
		end
	end
	// sk rises seen in one select frame; cleared while deselected
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			rises_q <= 6'h00;
		end else begin
			rises_q <= !ee_pins.cs ? 6'h00 : rises_q + 6'(ee_pins.sk && hi_q == 8'h00);
		end
	end
	a_wait_one: assert property ($rose(read || write) |-> waitrequest ##1 !waitrequest)
		else $error("bus answer not after exactly one wait cycle");
	a_sk_half: assert property ($fell(ee_pins.sk) |-> hi_q == HALF_CYC)
		else $error("serial clock high phase has wrong length");
	a_frame_len: assert property ($fell(ee_pins.cs) |-> rises_q == 6'h1a)
		else $error("word read frame without 26 serial clocks");
	a_cs_gap: assert property ($fell(ee_pins.cs) |-> !ee_pins.cs ##1 !ee_pins.cs)
		else $error("chip select gap shorter than two clocks");
	a_load_invalid: assert property ($rose(ee_pins.cs) |-> !cfg_valid)
		else $error("loaded values reported valid while loading");
	// values and valid land on the same edge, so only a second valid cycle must be stable
	a_cfg_stable: assert property (cfg_valid && $past(cfg_valid) |-> $stable(cfg_q))
		else $error("loaded values changed while reported valid");
	a_wake_gate: assert property (
		!cfg_q.option_bits[OPT_WAKE_PIN_EN] && !$past(cfg_q.option_bits[OPT_WAKE_PIN_EN])
		|-> !wake_pin)
		else $error("wake pin driven while disabled");
	a_ldps_off: assert property (
		cfg_q.option_bits[OPT_LDPS_OFF] && $past(cfg_q.option_bits[OPT_LDPS_OFF])
		|-> !tx_power_down)
		else $error("transmit powered down with saving disabled");
	a_rx_alive: assert property (rx_monitor_on)
		else $error("receive monitor switched off");
endmodule : eeprom_autoload_assertions

bind eeprom_autoload_mapper eeprom_autoload_assertions #(.HALF_CYC(HALF_CYC)) chk_u (
	.sys_clk(sys_clk),
	.rst(rst),
	.read(read),
	.write(write),
	.waitrequest(waitrequest),
	.ee_pins(ee_pins),
	.wake_pin(wake_pin),
	.tx_power_down(tx_power_down),
	.rx_monitor_on(rx_monitor_on),
	.cfg_q(cfg_q),
	.cfg_valid(cfg_valid)
);

// [ee_model.sv]
`timescale 1ns/1ps
// behavioural three-wire serial eeprom, read command only
module ee_model (
	// serial pins
	input wire logic cs,
	input wire logic sk,
	input wire logic di,
	output logic do_o
);
	logic [7:0] mem [0:127];
	logic [8:0] cmd_q;
	logic [15:0] word;
	int cnt_q;
	initial begin
		do_o = 1'b1;
		cmd_q = 9'h000;
	end
	assign word = {mem[2 * cmd_q[5:0] + 1], mem[2 * cmd_q[5:0]]};
	// start bit, opcode and address are shifted in on sk rising
	always @(posedge sk or negedge cs) begin
		if (!cs) begin
			cnt_q <= 0;
		end else begin
			if (cnt_q < 9) cmd_q <= {cmd_q[7:0], di};
			cnt_q <= cnt_q + 1;
		end
	end
	// data leaves on sk falling; outside the data phase the line shows no stale bit
	always @(negedge sk or negedge cs) begin
		if (cs && cmd_q[8:6] == 3'h6 && cnt_q == 9) begin
			do_o <= 1'b0;
		end else if (cs && cmd_q[8:6] == 3'h6 && cnt_q > 9 && cnt_q < 26) begin
			do_o <= word[25 - cnt_q];
		end else begin
			do_o <= ~do_o;
		end
	end
endmodule : ee_model

// [tb.sv]
`timescale 1ns/1ps
module tb;
	import eeprom_map_pkg::*;
	localparam logic [15:0] ID = 16'h5a3c; // arbitrary value
	logic sys_clk, rst, read, write, waitrequest, ee_do, link_down, signal_detect;
	logic wake_event, pci_reset, wake_pin, tx_power_down, rx_monitor_on, cfg_valid;
	logic [7:0] address;
	logic [31:0] writedata, readdata, rd;
	ee_pins_s ee_pins;
	load_cfg_s cfg_q;
	int fail_count = 0;
	int comparisons = 0;
	eeprom_autoload_mapper #(.ID_WORD(ID), .HALF_CYC(4)) DUT (
		.sys_clk(sys_clk), .rst(rst), .address(address), .read(read), .write(write),
		.writedata(writedata), .byteenable(4'hf), .readdata(readdata),
		.waitrequest(waitrequest), .ee_pins(ee_pins), .ee_do(ee_do),
		.link_down(link_down), .signal_detect(signal_detect),
		.tx_power_down(tx_power_down), .rx_monitor_on(rx_monitor_on),
		.wake_event(wake_event), .pci_reset(pci_reset), .wake_pin(wake_pin),
		.cfg_q(cfg_q), .cfg_valid(cfg_valid));
	ee_model EE (.cs(ee_pins.cs), .sk(ee_pins.sk), .di(ee_pins.di), .do_o(ee_do));
	// 40 mhz clock
	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	task final_report;
		if (fail_count == 0 && comparisons > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : final_report
	task chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// one avalon transfer; request held until waitrequest is seen low
	task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge sys_clk);
		address <= a;
		writedata <= d;
		read <= !wr;
		write <= wr;
		// look at waitrequest mid-cycle, away from the edge that launches it
		do begin
			@(negedge sys_clk);
			n++;
		end while (waitrequest !== 1'b0 && n < 50);
		if (n >= 50) fail_count++;
		rd = readdata;
		@(posedge sys_clk);
		read <= 1'b0;
		write <= 1'b0;
	endtask : bus
	function automatic logic [31:0] w4(input int b);
		return {EE.mem[b + 3], EE.mem[b + 2], EE.mem[b + 1], EE.mem[b]};
	endfunction : w4
	// poll status until the load has ended one way or the other
	task wait_load;
		int n;
		n = 0;
		do begin
			bus(1'b0, RA_STATUS, 32'h0);
			n++;
		end while ((rd[ST_BUSY] !== 1'b0 || rd[2:1] === 2'b00) && n < 3000);
	endtask : wait_load
	task reload(input logic t);
		bus(1'b1, RA_CTRL, {30'h0, t, 1'b1});
		wait_load;
	endtask : reload
	task pulse(input logic p);
		@(posedge sys_clk);
		if (p) pci_reset <= 1'b1;
		else wake_event <= 1'b1;
		@(posedge sys_clk);
		pci_reset <= 1'b0;
		wake_event <= 1'b0;
		repeat (4) @(posedge sys_clk);
	endtask : pulse
	task check_cfg(input logic t);
		bus(1'b0, RA_STATION_LO, 32'h0);
		chk(rd, w4(EB_STATION));
		bus(1'b0, RA_STATION_HI, 32'h0);
		chk(rd, {16'h0000, EE.mem[EB_STATION + 5], EE.mem[EB_STATION + 4]});
		bus(1'b0, RA_CONFIG, 32'h0);
		chk(rd, {EE.mem[EB_CFG4], EE.mem[EB_CFG3], EE.mem[EB_CFG1], EE.mem[EB_CFG0]});
		bus(1'b0, RA_POWER, 32'h0);
		chk(rd, {EE.mem[EB_OPT5], EE.mem[EB_PMCS], EE.mem[EB_PMC + 1], EE.mem[EB_PMC]});
		bus(1'b0, RA_PHY_A, 32'h0);
		chk(rd, w4(t ? EB_PHYA_T : EB_PHYA_U));
		bus(1'b0, RA_LINE_DRV, 32'h0);
		chk(rd, w4(t ? EB_LDRV_T : EB_LDRV_U));
		bus(1'b0, RA_PHY_B, 32'h0);
		chk(rd, {24'h00_0000, EE.mem[t ? EB_PHYB_T : EB_PHYB_U]});
	endtask : check_cfg
	// load after reset, then an unmapped write and read
	task t_load_u;
		wait_load;
		chk(rd[ST_VALID], 32'h1);
		check_cfg(1'b0);
		bus(1'b1, 8'h3c, 32'hffff_ffff);
		bus(1'b0, 8'h3c, 32'h0);
		chk(rd, 32'h0);
	endtask : t_load_u
	task t_load_t;
		reload(1'b1);
		check_cfg(1'b1);
		bus(1'b0, RA_CTRL, 32'h0);
		chk(rd, 32'h2);
	endtask : t_load_t
	// wake flag clearing under each option and capability setting
	task t_wake;
		pulse(1'b0);
		chk(wake_pin, 32'h1);
		pulse(1'b1);
		bus(1'b0, RA_WAKE, 32'h0);
		chk(rd[0], 32'h0);
		EE.mem[EB_PMC + 1] = 8'hc1;
		reload(1'b1);
		pulse(1'b0);
		pulse(1'b1);
		bus(1'b0, RA_WAKE, 32'h0);
		chk(rd[0], 32'h1);
		EE.mem[EB_PMC + 1] = 8'h41;
		EE.mem[EB_OPT5] = 8'h02;
		reload(1'b1);
		pulse(1'b1);
		bus(1'b0, RA_WAKE, 32'h0);
		chk(rd[0], 32'h1);
		bus(1'b1, RA_WAKE, 32'h1);
		bus(1'b0, RA_WAKE, 32'h0);
		chk(rd[0], 32'h0);
		EE.mem[EB_OPT5] = 8'h00;
		reload(1'b0);
		pulse(1'b0);
		chk(wake_pin, 32'h0);
	endtask : t_wake
	// link loss with saving enabled, then reconnect, then saving disabled
	task t_power;
		link_down <= 1'b1;
		repeat (8) @(posedge sys_clk);
		chk(tx_power_down, 32'h1);
		chk(rx_monitor_on, 32'h1);
		signal_detect <= 1'b1;
		repeat (8) @(posedge sys_clk);
		chk(tx_power_down, 32'h0);
		signal_detect <= 1'b0;
		EE.mem[EB_OPT5] = 8'h04;
		reload(1'b0);
		chk(tx_power_down, 32'h0);
		link_down <= 1'b0;
	endtask : t_power
	// wrong identification word: load abandoned, reset values kept
	task t_bad_id;
		EE.mem[0] = ~ID[7:0];
		@(posedge sys_clk);
		rst <= 1'b1;
		repeat (16) @(posedge sys_clk);
		rst <= 1'b0;
		wait_load;
		chk(rd[2:1], 32'h2);
		bus(1'b0, RA_CONFIG, 32'h0);
		chk(rd, 32'h0);
		chk(cfg_valid, 32'h0);
	endtask : t_bad_id
	// main sequence
	initial begin
		rst = 1'b1;
		{read, write, link_down, signal_detect, wake_event, pci_reset} = 6'h00;
		address = 8'h00;
		writedata = 32'h0;
		for (int i = 0; i < 128; i++) EE.mem[i] = 8'(i * 37 + 5);
		EE.mem[0] = ID[7:0];
		EE.mem[1] = ID[15:8];
		EE.mem[EB_PMC + 1] = 8'h41;
		EE.mem[EB_OPT5] = 8'h03;
		EE.mem[EB_CHECKSUM] = 8'h5e;
		EE.mem[EB_NETBOOT] = 8'h21;
		EE.mem[EB_PRODUCT_DATA] = 8'h82;
		repeat (16) @(posedge sys_clk);
		rst <= 1'b0;
		t_load_u;
		t_load_t;
		t_wake;
		t_power;
		t_bad_id;
		final_report;
	end
	// seven loads, the last one cut short, of some 5000 clocks each, with margin
	initial begin
		repeat (90000) @(posedge sys_clk);
		fail_count++;
		final_report;
	end
endmodule : tb
